// *** rtl/txsym_pkg.sv ***
`default_nettype none
package txsym_pkg;

    // ****************************************************************
    // Register indices, byte address is four times the index
    // ****************************************************************
    localparam int unsigned TXS_AW = 12;
    localparam logic [7:0] TXS_IDX_RATE_SEL = 8'h4C;
    localparam logic [7:0] TXS_IDX_P0_HIGH = 8'h4D;
    localparam logic [7:0] TXS_IDX_P0_LOW = 8'h4E;
    localparam logic [7:0] TXS_IDX_P1_HIGH = 8'h4F;
    localparam logic [7:0] TXS_IDX_P1_LOW = 8'h50;
    localparam logic [7:0] TXS_IDX_P2 = 8'h51;
    localparam logic [7:0] TXS_IDX_P3 = 8'h52;
    localparam logic [7:0] TXS_IDX_LONG_LEN = 8'h53;
    localparam logic [7:0] TXS_IDX_SHORT_LEN = 8'h54;
    localparam logic [3:0] TXS_NREG = 4'h9;
    localparam logic [3:0] TXS_UNMAPPED = 4'hF;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int unsigned TXS_SHORT_SC_BIT = 7;
    localparam int unsigned TXS_SHORT_RATE_LSB = 4;
    localparam int unsigned TXS_LONG_SC_BIT = 3;
    localparam int unsigned TXS_LONG_RATE_LSB = 0;
    localparam int unsigned TXS_HI_LEN_LSB = 4;
    localparam int unsigned TXS_LO_LEN_LSB = 0;
    localparam logic [7:0] TXS_REG_RESET = 8'h00;
    localparam logic [7:0] TXS_SHORT_LEN_MASK = 8'h77;
    localparam logic [2:0] TXS_RATE_RSVD_MAX = 3'h1;
    localparam logic [1:0] TXS_RESP_OKAY = 2'h0;
    localparam logic [1:0] TXS_RESP_SLVERR = 2'h2;

    typedef enum logic [0:0] {
        TXS_IDLE = 1'b0,
        TXS_SHIFT = 1'b1
    } txs_state_t;

    typedef struct packed {
        logic [15:0] pattern;
        logic [3:0] last_idx;
        logic [2:0] rate;
        logic sc;
    } txs_sym_t;

    // Maps a byte address onto a register number
    function automatic logic [3:0] txs_decode(input logic [TXS_AW-1:0] a);
        logic [3:0] n;
        n = TXS_UNMAPPED;
        for (int i = 0; i < int'(TXS_NREG); i++)
        begin
            if (a == {2'h0, 8'(TXS_IDX_RATE_SEL + 8'(i)), 2'h0})
            begin
                n = 4'(i);
            end
        end
        return n;
    endfunction

endpackage
`default_nettype wire

// *** rtl/txsym_pattern_cfg.sv ***
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Bit 7 picks short pair subcarrier 424/848
// - Bits 6..4 pick short pair bit rate
// - Bit 3 picks long pair subcarrier 424/848
// - Bits 2..0 pick long pair bit rate
// - First pattern: high byte above low byte
// - Second pattern: high byte above low byte
// - Third pattern is one full byte
// - Fourth pattern is one full byte
// - Second length is bits 7..4 plus one
// - First length is bits 3..0 plus one
// - Fourth length is bits 6..4 plus one
// - Third length is bits 2..0 plus one
module txsym_pattern_cfg
    import txsym_pkg::*;
(
    // Clock, reset, enable
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    // AXI4-Lite write
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [TXS_AW-1:0] s_axi_awaddr_i,
    input wire logic [2:0] s_axi_awprot_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    output logic [1:0] s_axi_bresp_o,
    // AXI4-Lite read
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    input wire logic [TXS_AW-1:0] s_axi_araddr_i,
    input wire logic [2:0] s_axi_arprot_i,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    // Symbol encoder side
    input wire logic sym_start_i,
    input wire logic [1:0] sym_sel_i,
    input wire logic bit_adv_i,
    output logic sym_bit_o,
    output logic sym_active_o,
    output logic sym_last_o,
    output logic [2:0] sym_rate_o,
    output logic sym_sc_o,
    output logic sym_rate_rsvd_o
);

    // ****************************************************************
    // Register bus slave
    // ****************************************************************
    logic [7:0] regs_r [9];
    logic aw_full_r;
    logic w_full_r;
    logic [TXS_AW-1:0] awaddr_r;
    logic [7:0] wdata_r;
    logic wstrb0_r;
    logic awready_r;
    logic wready_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic arready_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    wire aw_take = s_axi_awvalid_i & awready_r;
    wire w_take = s_axi_wvalid_i & wready_r;
    wire do_write = aw_full_r & w_full_r & ~bvalid_r;
    wire aw_full_nxt = aw_full_r ? ~do_write : aw_take;
    wire w_full_nxt = w_full_r ? ~do_write : w_take;
    wire [3:0] wr_num = txs_decode(awaddr_r);
    wire wr_hit = wr_num != TXS_UNMAPPED;
    wire wr_en = do_write & wr_hit & wstrb0_r;
    wire bvalid_nxt = do_write | (bvalid_r & ~s_axi_bready_i);

    wire ar_take = s_axi_arvalid_i & arready_r;
    wire rvalid_nxt = ar_take | (rvalid_r & ~s_axi_rready_i);
    wire [3:0] rd_num = txs_decode(s_axi_araddr_i);
    wire rd_hit = rd_num != TXS_UNMAPPED;
    wire [7:0] rd_byte = rd_hit ? regs_r[rd_num] : 8'h00;
    wire [7:0] wr_byte = (wr_num == 4'h8) ?
        (wdata_r & TXS_SHORT_LEN_MASK) : wdata_r;

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= 8'h00;
            wstrb0_r <= 1'b0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= TXS_RESP_OKAY;
        end
        else if (clk_en_i)
        begin
            aw_full_r <= aw_full_nxt;
            w_full_r <= w_full_nxt;
            awready_r <= ~aw_full_nxt;
            wready_r <= ~w_full_nxt;
            bvalid_r <= bvalid_nxt;
            if (aw_take)
            begin
                awaddr_r <= s_axi_awaddr_i;
            end
            if (w_take)
            begin
                wdata_r <= s_axi_wdata_i[7:0];
                wstrb0_r <= s_axi_wstrb_i[0];
            end
            if (do_write)
            begin
                bresp_r <= wr_hit ? TXS_RESP_OKAY : TXS_RESP_SLVERR;
            end
        end
    end

    // Register storage
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            for (int i = 0; i < 9; i++)
            begin
                regs_r[i] <= TXS_REG_RESET;
            end
        end
        else if (clk_en_i && wr_en)
        begin
            regs_r[wr_num] <= wr_byte;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= TXS_RESP_OKAY;
        end
        else if (clk_en_i)
        begin
            arready_r <= ~rvalid_nxt;
            rvalid_r <= rvalid_nxt;
            if (ar_take)
            begin
                rdata_r <= {24'h00_0000, rd_byte};
                rresp_r <= rd_hit ? TXS_RESP_OKAY : TXS_RESP_SLVERR;
            end
        end
    end

    assign s_axi_awready_o = awready_r;
    assign s_axi_wready_o = wready_r;
    assign s_axi_bvalid_o = bvalid_r;
    assign s_axi_bresp_o = bresp_r;
    assign s_axi_arready_o = arready_r;
    assign s_axi_rvalid_o = rvalid_r;
    assign s_axi_rdata_o = rdata_r;
    assign s_axi_rresp_o = rresp_r;

    // ****************************************************************
    // Symbol configuration
    // ****************************************************************
    wire [7:0] rate_sel = regs_r[0];
    wire [7:0] long_len = regs_r[7];
    wire [7:0] short_len = regs_r[8];
    txs_sym_t cfg [4];

    assign cfg[0] = {regs_r[1], regs_r[2],
        long_len[TXS_LO_LEN_LSB +: 4],
        rate_sel[TXS_LONG_RATE_LSB +: 3],
        rate_sel[TXS_LONG_SC_BIT]};
    assign cfg[1] = {regs_r[3], regs_r[4],
        long_len[TXS_HI_LEN_LSB +: 4],
        rate_sel[TXS_LONG_RATE_LSB +: 3],
        rate_sel[TXS_LONG_SC_BIT]};
    assign cfg[2] = {8'h00, regs_r[5],
        1'b0, short_len[TXS_LO_LEN_LSB +: 3],
        rate_sel[TXS_SHORT_RATE_LSB +: 3],
        rate_sel[TXS_SHORT_SC_BIT]};
    assign cfg[3] = {8'h00, regs_r[6],
        1'b0, short_len[TXS_HI_LEN_LSB +: 3],
        rate_sel[TXS_SHORT_RATE_LSB +: 3],
        rate_sel[TXS_SHORT_SC_BIT]};

    wire txs_sym_t sel_cfg = cfg[sym_sel_i];

    // ****************************************************************
    // Pattern serializer
    // ****************************************************************
    txs_state_t state_r;
    logic [15:0] pat_r;
    logic [3:0] cnt_r;
    logic bit_r;
    logic last_r;
    logic [2:0] rate_r;
    logic sc_r;
    logic rsvd_r;

    wire start_ok = sym_start_i & (state_r == TXS_IDLE);
    wire shift_ok = bit_adv_i & (state_r == TXS_SHIFT);
    wire at_end = shift_ok & (cnt_r == 4'h0);
    wire [3:0] cnt_dec = 4'(cnt_r - 4'h1);

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            state_r <= TXS_IDLE;
            pat_r <= 16'h0000;
            cnt_r <= 4'h0;
            bit_r <= 1'b0;
            last_r <= 1'b0;
            rate_r <= 3'h0;
            sc_r <= 1'b0;
            rsvd_r <= 1'b0;
        end
        else if (clk_en_i)
        begin
            case (state_r)
                TXS_IDLE:
                begin
                    if (start_ok)
                    begin
                        state_r <= TXS_SHIFT;
                        pat_r <= sel_cfg.pattern;
                        cnt_r <= sel_cfg.last_idx;
                        bit_r <= sel_cfg.pattern[sel_cfg.last_idx];
                        last_r <= sel_cfg.last_idx == 4'h0;
                        rate_r <= sel_cfg.rate;
                        sc_r <= sel_cfg.sc;
                        // Reserved codes are flagged, never acted on
                        rsvd_r <= sel_cfg.rate <= TXS_RATE_RSVD_MAX;
                    end
                end
                TXS_SHIFT:
                begin
                    if (at_end)
                    begin
                        state_r <= TXS_IDLE;
                        bit_r <= 1'b0;
                        last_r <= 1'b0;
                    end
                    else if (shift_ok)
                    begin
                        cnt_r <= cnt_dec;
                        bit_r <= pat_r[cnt_dec];
                        last_r <= cnt_dec == 4'h0;
                    end
                end
                default:
                begin
                    state_r <= TXS_IDLE;
                end
            endcase
        end
    end

    assign sym_bit_o = bit_r;
    assign sym_active_o = state_r == TXS_SHIFT;
    assign sym_last_o = last_r;
    assign sym_rate_o = rate_r;
    assign sym_sc_o = sc_r;
    assign sym_rate_rsvd_o = rsvd_r;

    // ****************************************************************
    // Checks
    // ****************************************************************
    logic [4:0] seen_r;
    logic [4:0] want_r;

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            seen_r <= 5'h00;
            want_r <= 5'h00;
        end
        else if (clk_en_i)
        begin
            if (start_ok)
            begin
                seen_r <= 5'h01;
                case (sym_sel_i)
                    2'h0: want_r <= 5'(long_len[3:0]) + 5'h01;
                    2'h1: want_r <= 5'(long_len[7:4]) + 5'h01;
                    2'h2: want_r <= 5'(short_len[2:0]) + 5'h01;
                    default: want_r <= 5'(short_len[6:4]) + 5'h01;
                endcase
            end
            else if (shift_ok && !at_end)
            begin
                seen_r <= 5'(seen_r + 5'h01);
            end
        end
    end

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    chk_short_sc: assert property (
        clk_en_i && start_ok && sym_sel_i[1]
        |=> sym_sc_o == $past(rate_sel[7]))
        else $error("short pair subcarrier wrong");
    chk_short_rate: assert property (
        clk_en_i && start_ok && sym_sel_i[1]
        |=> sym_rate_o == $past(rate_sel[6:4]))
        else $error("short pair rate wrong");
    chk_long_sc: assert property (
        clk_en_i && start_ok && !sym_sel_i[1]
        |=> sym_sc_o == $past(rate_sel[3]))
        else $error("long pair subcarrier wrong");
    chk_long_rate: assert property (
        clk_en_i && start_ok && !sym_sel_i[1]
        |=> sym_rate_o == $past(rate_sel[2:0]))
        else $error("long pair rate wrong");
    chk_first_msb: assert property (
        clk_en_i && start_ok && sym_sel_i == 2'h0
        && long_len[3:0] == 4'hF |=> sym_bit_o == $past(regs_r[1][7]))
        else $error("first pattern top bit wrong");
    chk_second_lsb: assert property (
        clk_en_i && start_ok && sym_sel_i == 2'h1
        && long_len[7:4] == 4'h0 |=> sym_bit_o == $past(regs_r[4][0]))
        else $error("second pattern low bit wrong");
    chk_third_msb: assert property (
        clk_en_i && start_ok && sym_sel_i == 2'h2
        && short_len[2:0] == 3'h7 |=> sym_bit_o == $past(regs_r[5][7]))
        else $error("third pattern top bit wrong");
    chk_fourth_msb: assert property (
        clk_en_i && start_ok && sym_sel_i == 2'h3
        && short_len[6:4] == 3'h7 |=> sym_bit_o == $past(regs_r[6][7]))
        else $error("fourth pattern top bit wrong");
    chk_bit_count: assert property (
        clk_en_i && at_end |-> seen_r == want_r)
        else $error("symbol bit count wrong");
    chk_last_flag: assert property (
        clk_en_i && at_end |-> sym_last_o ##1 !sym_active_o)
        else $error("last bit flag wrong");
    chk_rsvd_read: assert property (
        clk_en_i && ar_take && rd_num == 4'h8
        |=> s_axi_rvalid_o && s_axi_rdata_o[31:8] == 24'h00_0000
        && !s_axi_rdata_o[7] && !s_axi_rdata_o[3])
        else $error("reserved bits not zero");

endmodule
`default_nettype wire

// *** test/txsb_enc_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****
// Encoder that pulls symbol bits, promptly or with stalls
// ****
module txsb_enc_model (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // Bench side
    input wire logic go_i,
    input wire logic [1:0] sel_i,
    input wire logic slow_i,
    output logic done_o,
    output logic [15:0] bits_o,
    output logic [4:0] cnt_o,
    output logic [4:0] cfg_o,
    // Serializer side
    output logic start_o,
    output logic [1:0] sel_o,
    output logic adv_o,
    input wire logic bit_i,
    input wire logic active_i,
    input wire logic last_i,
    input wire logic [2:0] rate_i,
    input wire logic sc_i,
    input wire logic rsvd_i
);
    logic busy_r;
    logic take_w;
    assign take_w = busy_r && active_i && adv_o;
    initial
    begin
        start_o = 1'b0;
        sel_o = 2'h0;
        adv_o = 1'b0;
        done_o = 1'b0;
    end
    always @(posedge core_clk_i)
    begin
        done_o <= 1'b0;
        if (sys_rst_i)
        begin
            busy_r <= 1'b0;
            start_o <= 1'b0;
            adv_o <= 1'b0;
        end
        else
        begin
            if (go_i && !busy_r)
            begin
                busy_r <= 1'b1;
                start_o <= 1'b1;
                sel_o <= sel_i;
                bits_o <= 16'h0000;
                cnt_o <= 5'h00;
            end
            // Start is held until the serializer shows it was taken
            if (start_o && active_i)
                start_o <= 1'b0;
            if (take_w)
            begin
                bits_o <= {bits_o[14:0], bit_i};
                cnt_o <= cnt_o + 5'h01;
                busy_r <= !last_i;
                done_o <= last_i;
                cfg_o <= {rsvd_i, sc_i, rate_i};
            end
            adv_o <= busy_r && active_i && !(take_w && last_i)
                && (!slow_i || $urandom_range(2) == 0);
        end
    end
endmodule
`default_nettype wire

// *** test/tx_symbol_pattern_config_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****
// Register bus and serializer bench
// ****
module tx_symbol_pattern_config_tb_top
    import txsym_pkg::*;
;
    logic core_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic awv = 1'b0, aw_rdy, wv = 1'b0, w_rdy, bv, br = 1'b0;
    logic arv = 1'b0, ar_rdy, rv, rr = 1'b0;
    logic [11:0] awa = 12'h000, ara = 12'h000;
    logic [31:0] wd = 32'h00000000, rd;
    logic [3:0] ws = 4'h0;
    logic [1:0] bresp, rresp, ssel, msel = 2'h0;
    logic start, adv, sbit, act, last, sc, rsvd, go = 1'b0, slow = 1'b0;
    logic done;
    logic en = 1'b1;
    logic [2:0] rate;
    logic [15:0] mbits;
    logic [4:0] mcnt, mcfg;
    logic [7:0] regs_e [9];
    int fails = 0;
    int n_compared = 0;
    always #5 core_clk_i = ~core_clk_i;
    txsym_pattern_cfg i_dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
        .clk_en_i(en), .s_axi_awvalid_i(awv), .s_axi_awready_o(aw_rdy),
        .s_axi_awaddr_i(awa), .s_axi_awprot_i(3'h0), .s_axi_wvalid_i(wv),
        .s_axi_wready_o(w_rdy), .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws),
        .s_axi_bvalid_o(bv), .s_axi_bready_i(br), .s_axi_bresp_o(bresp),
        .s_axi_arvalid_i(arv), .s_axi_arready_o(ar_rdy),
        .s_axi_araddr_i(ara), .s_axi_arprot_i(3'h0), .s_axi_rvalid_o(rv),
        .s_axi_rready_i(rr), .s_axi_rdata_o(rd), .s_axi_rresp_o(rresp),
        .sym_start_i(start), .sym_sel_i(ssel), .bit_adv_i(adv),
        .sym_bit_o(sbit), .sym_active_o(act), .sym_last_o(last),
        .sym_rate_o(rate), .sym_sc_o(sc), .sym_rate_rsvd_o(rsvd));
    txsb_enc_model i_enc (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
        .go_i(go), .sel_i(msel), .slow_i(slow), .done_o(done),
        .bits_o(mbits), .cnt_o(mcnt), .cfg_o(mcfg), .start_o(start),
        .sel_o(ssel), .adv_o(adv), .bit_i(sbit), .active_i(act),
        .last_i(last), .rate_i(rate), .sc_i(sc), .rsvd_i(rsvd));

    task automatic complete_run();
        if (fails == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic guard(inout int n);
        n++;
        if (n > 300)
        begin
            $display("CHECK FAILED wait expected answer seen none");
            fails++;
            complete_run();
        end
    endtask

    task automatic cmp_val(string nm, logic [31:0] e, logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask

    task automatic cmp_resp(string nm, logic [1:0] e, logic [1:0] g);
        n_compared++;
        if (g !== e)
        begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask

    task automatic bus_wr(logic [11:0] a, logic [7:0] d, logic s,
        output logic [1:0] r);
        logic ah, wh, bh;
        int n;
        n = 0;
        bh = 1'b0;
        @(posedge core_clk_i);
        awa <= a;
        wd <= {24'h000000, d};
        ws <= {3'h0, s};
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        while (!bh)
        begin
            @(negedge core_clk_i);
            ah = awv && aw_rdy;
            wh = wv && w_rdy;
            bh = bv;
            r = bresp;
            guard(n);
            @(posedge core_clk_i);
            if (ah)
                awv <= 1'b0;
            if (wh)
                wv <= 1'b0;
            if (bh)
                br <= 1'b0;
        end
    endtask

    task automatic bus_rd(logic [11:0] a, output logic [31:0] d,
        output logic [1:0] r);
        logic ah, rh;
        int n;
        n = 0;
        rh = 1'b0;
        @(posedge core_clk_i);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        while (!rh)
        begin
            @(negedge core_clk_i);
            ah = arv && ar_rdy;
            rh = rv;
            d = rd;
            r = rresp;
            guard(n);
            @(posedge core_clk_i);
            if (ah)
                arv <= 1'b0;
            if (rh)
                rr <= 1'b0;
        end
    endtask

    // Expected {rsvd, sc, rate, length, valid bits} of one symbol
    function automatic logic [25:0] exp_sym(logic [1:0] s);
        logic [15:0] p;
        logic [4:0] l;
        logic [3:0] f;
        p = s == 2'h0 ? {regs_e[1], regs_e[2]} : s == 2'h1 ?
            {regs_e[3], regs_e[4]} : {8'h00, regs_e[3'(s) + 3'h3]};
        l = 5'h01 + (s == 2'h0 ? {1'b0, regs_e[7][3:0]} : s == 2'h1 ?
            {1'b0, regs_e[7][7:4]} : s == 2'h2 ? {2'h0, regs_e[8][2:0]} :
            {2'h0, regs_e[8][6:4]});
        f = s[1] ? regs_e[0][7:4] : regs_e[0][3:0];
        p = p & 16'((17'h00001 << l) - 17'h00001);
        return {f[2:0] <= 3'h1, f[3], f[2:0], l, p};
    endfunction

    initial
    begin
        logic [1:0] r;
        logic [31:0] d;
        logic [7:0] v;
        logic [25:0] e;
        int n;
        void'($urandom(32'h57E7FC1B));
        repeat (12) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        for (int i = 0; i < 9; i++)
        begin
            bus_rd(12'h130 + 12'(4 * i), d, r);
            cmp_val("reset value", 32'h00000000, d);
            cmp_resp("read resp", TXS_RESP_OKAY, r);
        end
        bus_wr(12'h154, 8'hA5, 1'b1, r);
        cmp_resp("unmapped write", TXS_RESP_SLVERR, r);
        bus_rd(12'h000, d, r);
        cmp_resp("unmapped read", TXS_RESP_SLVERR, r);
        cmp_val("unmapped data", 32'h00000000, d);
        for (int t = 0; t < 16; t++)
        begin
            for (int i = 0; i < 9; i++)
            begin
                v = 8'($urandom);
                // Walk every rate code through both pair fields
                if (i == 0)
                    v[6:0] = {t[2:0], v[3], ~t[2:0]};
                if (i > 6 && t < 2)
                    v = t == 0 ? 8'h00 : 8'hFF;
                bus_wr(12'h130 + 12'(4 * i), v, 1'b1, r);
                regs_e[i] = i == 8 ? v & TXS_SHORT_LEN_MASK : v;
            end
            v = 8'($urandom_range(8));
            bus_wr(12'h130 + 12'(4 * v), 8'($urandom), 1'b0, r);
            cmp_resp("masked write", TXS_RESP_OKAY, r);
            for (int i = 0; i < 9; i++)
            begin
                bus_rd(12'h130 + 12'(4 * i), d, r);
                cmp_val("readback", {24'h000000, regs_e[i]}, d);
            end
            for (int s = 0; s < 4; s++)
            begin
                n = 0;
                @(posedge core_clk_i);
                go <= 1'b1;
                msel <= 2'(s);
                slow <= t[0];
                // Second symbol first waits with the clock enable low
                en <= s != 1;
                @(posedge core_clk_i);
                go <= 1'b0;
                if (s == 1)
                begin
                    repeat (4) @(negedge core_clk_i);
                    cmp_val("frozen start", 32'h00000000, {31'h0, act});
                    @(posedge core_clk_i);
                    en <= 1'b1;
                end
                do
                begin
                    @(negedge core_clk_i);
                    guard(n);
                end
                while (done !== 1'b1);
                e = exp_sym(2'(s));
                cmp_val("pattern", {16'h0000, e[15:0]}, {16'h0000, mbits});
                cmp_val("length", {27'h0, e[20:16]}, {27'h0, mcnt});
                cmp_val("rate", {29'h0, e[23:21]}, {29'h0, mcfg[2:0]});
                cmp_val("subcarrier", {31'h0, e[24]}, {31'h0, mcfg[3]});
                cmp_val("reserved rate", {31'h0, e[25]}, {31'h0, mcfg[4]});
                cmp_val("end", 32'h00000000, {30'h0, act, last});
            end
        end
        complete_run();
    end
endmodule
`default_nettype wire
